// ==== src/ddbl_host.v ====
// host controller that drives the double-buffered dac pins
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "ddbl_map.vh"
`default_nettype none
module ddbl_host
(
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  output reg  [15:0] bus_o,
  output reg         select_n_o,
  output reg         write_n_o,
  output reg         upper_byte_select_o,
  output reg         transfer_strobe_n_o,
  output reg         async_zero_n_o,
  output reg         sleep_n_o
);
  // ==========================================
  // states
  localparam [5:0] ST_IDLE  = 6'b00_0001;
  localparam [5:0] ST_SETUP = 6'b00_0010;
  localparam [5:0] ST_WLOW  = 6'b00_0100;
  localparam [5:0] ST_WHOLD = 6'b00_1000;
  localparam [5:0] ST_LOAD  = 6'b01_0000;
  localparam [5:0] ST_CLEAR = 6'b10_0000;
  localparam [31:0] PULSE_W = `DDBL_T_PULSE_CYC;
  localparam [7:0]  PULSE   = PULSE_W[7:0];

  reg  [5:0]  state_reg;
  reg  [7:0]  cnt_reg;
  reg  [7:0]  ctrl_reg;
  reg  [15:0] data_reg;
  reg         phase_reg;
  reg         pend_wr_reg;
  reg         pend_ld_reg;
  reg         pend_clr_reg;
  reg  [7:0]  done_reg;
  wire        cmd_wr;
  wire        cnt_done;
  wire        byte_mode;

  assign cmd_wr    = wr_i && (addr_i == `DDBL_ADDR_CMD);
  assign cnt_done  = (cnt_reg == 8'h00);
  assign byte_mode = ctrl_reg[`DDBL_CTRL_BYTEMODE];

  // ==========================================
  // software registers
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_reg <= `DDBL_CTRL_RESET;
      data_reg <= 16'h0000;
      rdata_o  <= 16'h0000;
    end
    else
    begin
      if (wr_i && addr_i == `DDBL_ADDR_CTRL)
        ctrl_reg <= wdata_i[7:0];
      if (wr_i && addr_i == `DDBL_ADDR_DATA)
        data_reg <= wdata_i;
      rdata_o <= 16'h0000;
      if (rd_i)
      begin
        case (addr_i)
          `DDBL_ADDR_CTRL:   rdata_o <= {8'h00, ctrl_reg};
          `DDBL_ADDR_DATA:   rdata_o <= data_reg;
          `DDBL_ADDR_STATUS: rdata_o <= {done_reg, 2'b00, state_reg};
          default:           rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================
  // pin sequencer
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg           <= ST_IDLE;
      cnt_reg             <= 8'h00;
      phase_reg           <= 1'b0;
      pend_wr_reg         <= 1'b0;
      pend_ld_reg         <= 1'b0;
      pend_clr_reg        <= 1'b0;
      done_reg            <= 8'h00;
      bus_o               <= 16'h0000;
      select_n_o          <= 1'b1;
      write_n_o           <= 1'b1;
      upper_byte_select_o <= 1'b0;
      transfer_strobe_n_o <= 1'b1;
      async_zero_n_o      <= 1'b1;
      sleep_n_o           <= 1'b1;
    end
    else
    begin
      sleep_n_o <= ~ctrl_reg[`DDBL_CTRL_SLEEP];
      if (cmd_wr)
      begin
        pend_wr_reg  <= pend_wr_reg  | wdata_i[`DDBL_CMD_WRITE];
        pend_ld_reg  <= pend_ld_reg  | wdata_i[`DDBL_CMD_LOAD];
        pend_clr_reg <= pend_clr_reg | wdata_i[`DDBL_CMD_CLEAR];
      end
      if (rd_i && addr_i == `DDBL_ADDR_STATUS)
        done_reg <= 8'h00;
      case (state_reg)
        ST_IDLE:
        begin
          phase_reg <= 1'b0;
          if (pend_clr_reg)
          begin
            // a command arriving on the pick-up edge stays pending
            pend_clr_reg   <= cmd_wr & wdata_i[`DDBL_CMD_CLEAR];
            async_zero_n_o <= 1'b0;
            cnt_reg        <= PULSE;
            state_reg      <= ST_CLEAR;
          end
          else if (pend_wr_reg)
          begin
            pend_wr_reg <= cmd_wr & wdata_i[`DDBL_CMD_WRITE];
            // bus and byte select settle before select goes low
            if (byte_mode)
            begin
              bus_o <= {8'h00, data_reg[7:0]};
              upper_byte_select_o <= 1'b0;
            end
            else
              bus_o <= data_reg;
            cnt_reg   <= PULSE;
            state_reg <= ST_SETUP;
          end
          else if (pend_ld_reg)
          begin
            pend_ld_reg         <= cmd_wr & wdata_i[`DDBL_CMD_LOAD];
            transfer_strobe_n_o <= 1'b0;
            cnt_reg             <= PULSE;
            state_reg           <= ST_LOAD;
          end
        end
        ST_SETUP:
        begin
          select_n_o <= 1'b0;
          write_n_o  <= 1'b0;
          if (ctrl_reg[`DDBL_CTRL_SYNC])
            transfer_strobe_n_o <= 1'b0;
          cnt_reg   <= PULSE;
          state_reg <= ST_WLOW;
        end
        ST_WLOW:
        begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_done)
          begin
            write_n_o <= 1'b1;
            cnt_reg   <= PULSE;
            state_reg <= ST_WHOLD;
          end
        end
        ST_WHOLD:
        begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_done)
          begin
            select_n_o          <= 1'b1;
            transfer_strobe_n_o <= 1'b1;
            if (byte_mode && !phase_reg)
            begin
              phase_reg <= 1'b1;
              // high byte: data bits 8..11 low, gain and buffer on 6 and 7
              bus_o <= {8'h00, data_reg[`DDBL_DATA_BUF], data_reg[`DDBL_DATA_GAIN],
                        2'b00, data_reg[11:8]};
              upper_byte_select_o <= 1'b1;
              cnt_reg   <= PULSE;
              state_reg <= ST_SETUP;
            end
            else
            begin
              upper_byte_select_o <= 1'b0;
              done_reg[0] <= 1'b1;
              state_reg   <= ST_IDLE;
            end
          end
        end
        ST_LOAD:
        begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_done)
          begin
            transfer_strobe_n_o <= 1'b1;
            done_reg[1] <= 1'b1;
            state_reg   <= ST_IDLE;
          end
        end
        ST_CLEAR:
        begin
          cnt_reg <= cnt_reg - 8'h01;
          if (cnt_done)
          begin
            async_zero_n_o <= 1'b1;
            done_reg[2] <= 1'b1;
            state_reg   <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // ddbl_host
`default_nettype wire

// ==== src/ddbl_map.vh ====
// constants for the dac double buffer load host controller
`ifndef DDBL_MAP_VH
`define DDBL_MAP_VH
// software register offsets
`define DDBL_ADDR_CTRL      4'h0
`define DDBL_ADDR_DATA      4'h1
`define DDBL_ADDR_CMD       4'h2
`define DDBL_ADDR_STATUS    4'h3
// ctrl fields
`define DDBL_CTRL_SLEEP     0
`define DDBL_CTRL_BYTEMODE  1
`define DDBL_CTRL_SYNC      2
`define DDBL_CTRL_RESET     8'h00
// data fields (word layout on the 16-bit bus, then the high-byte layout)
`define DDBL_DATA_BUF       15
`define DDBL_DATA_GAIN      14
`define DDBL_BYTE_BUF       7
`define DDBL_BYTE_GAIN      6
// cmd bits
`define DDBL_CMD_WRITE      0
`define DDBL_CMD_LOAD       1
`define DDBL_CMD_CLEAR      2
// pin timing in ns and cycles at 4 ns
`define DDBL_CLK_NS         4
`define DDBL_T_PULSE_NS     20
`define DDBL_T_PULSE_CYC    ((`DDBL_T_PULSE_NS + `DDBL_CLK_NS - 1) / `DDBL_CLK_NS)
`endif

// ==== testbench/ddbl_dac_model.sv ====
// behavioural model of the double-buffered dac
`timescale 1ns/1ps
`default_nettype none
module ddbl_dac_model (
  input wire logic select_n_i,
  input wire logic write_n_i,
  input wire logic upper_byte_select_i,
  input wire logic transfer_strobe_n_i,
  input wire logic async_zero_n_i,
  input wire logic sleep_n_i,
  input wire logic byte_i,
  input wire logic [15:0] bus_i,
  output var logic [15:0] in_o,
  output var logic [15:0] dac_o,
  output wire logic drive_o
);
  initial in_o = 16'h0;
  initial dac_o = 16'h0;
  assign drive_o = sleep_n_i;
  always @(posedge write_n_i or negedge async_zero_n_i)
    if (!async_zero_n_i) in_o <= 16'h0;
    else if (!select_n_i && !byte_i) in_o <= bus_i & 16'hcfff;
    else if (!select_n_i && upper_byte_select_i) in_o[15:8] <= {bus_i[7:6], 2'h0, bus_i[3:0]};
    else if (!select_n_i) in_o[7:0] <= bus_i[7:0];
  always @*
    if (!async_zero_n_i) dac_o = 16'h0;
    else if (!transfer_strobe_n_i) dac_o = in_o;
endmodule // ddbl_dac_model
`default_nettype wire

// ==== testbench/ddbl_sva.sv ====
// concurrent checks on the dac host pins
`timescale 1ns/1ps
`default_nettype none
module ddbl_sva (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] bus_o,
  input wire logic select_n_o,
  input wire logic write_n_o,
  input wire logic upper_byte_select_o,
  input wire logic transfer_strobe_n_o,
  input wire logic async_zero_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sel_on_wr_a: assert property (!write_n_o |-> !select_n_o) else $error("write unselected");
  wr_width_a: assert property ($fell(write_n_o) |-> !write_n_o[*6] ##1 write_n_o) else $error("write width");
  bus_hold_a: assert property ($rose(write_n_o) |-> $stable(bus_o) && $stable(upper_byte_select_o))
    else $error("bus moved");
  sel_hold_a: assert property ($rose(write_n_o) |-> !select_n_o) else $error("select early");
  hi_byte_a: assert property (!write_n_o && upper_byte_select_o |-> bus_o[5:4] == 2'h0) else $error("high byte");
  clr_width_a: assert property ($fell(async_zero_n_o) |-> !async_zero_n_o[*6] ##1 async_zero_n_o)
    else $error("clear width");
  clr_excl_a: assert property (!async_zero_n_o |-> write_n_o && transfer_strobe_n_o) else $error("clear overlap");
  ld_width_a: assert property ($fell(transfer_strobe_n_o) && write_n_o |-> !transfer_strobe_n_o[*6] ##1
    transfer_strobe_n_o) else $error("load width");
  sel_bus_hold_a: assert property (!select_n_o && $past(!select_n_o) |-> $stable(bus_o)
    && $stable(upper_byte_select_o)) else $error("bus moved while selected");
endmodule // ddbl_sva
bind ddbl_host ddbl_sva i_sva (
  .clk_i               (clk_i),
  .reset_n_i           (reset_n_i),
  .bus_o               (bus_o),
  .select_n_o          (select_n_o),
  .write_n_o           (write_n_o),
  .upper_byte_select_o (upper_byte_select_o),
  .transfer_strobe_n_o (transfer_strobe_n_o),
  .async_zero_n_o      (async_zero_n_o)
);
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the dac host controller
`timescale 1ns/1ps
`include "ddbl_map.vh"
`default_nettype none
module tb_top;
  logic clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, byte_mode = 0, drive;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0, rdata_o, bus_o, in_q, dac_q, d, e, old, s;
  logic select_n_o, write_n_o, upper_byte_select_o, transfer_strobe_n_o, async_zero_n_o, sleep_n_o;
  int failures = 0, n_compared = 0, k, i;
  initial forever #2 clk_i = ~clk_i;
  ddbl_host i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .bus_o(bus_o), .select_n_o(select_n_o), .write_n_o(write_n_o),
    .upper_byte_select_o(upper_byte_select_o), .transfer_strobe_n_o(transfer_strobe_n_o),
    .async_zero_n_o(async_zero_n_o), .sleep_n_o(sleep_n_o));
  ddbl_dac_model i_dac (.select_n_i(select_n_o), .write_n_i(write_n_o), .upper_byte_select_i(upper_byte_select_o),
    .transfer_strobe_n_i(transfer_strobe_n_o), .async_zero_n_i(async_zero_n_o), .sleep_n_i(sleep_n_o),
    .byte_i(byte_mode), .bus_i(bus_o), .in_o(in_q), .dac_o(dac_q), .drive_o(drive));
  function logic [15:0] exp_in(input logic [15:0] v);
    return v & 16'hcfff;
  endfunction
  task chk(input logic [15:0] seen, want);
    n_compared++;
    if (seen !== want)
    begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task report_and_stop;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1 q = rdata_o;
  endtask
  // issue one command and poll its done flag
  task run(input int b);
    wr(`DDBL_ADDR_CMD, 16'h1 << b);
    s = 16'h0;
    for (i = 0; i < 200 && !s[8 + b]; i++) rd(`DDBL_ADDR_STATUS, s);
    if (!s[8 + b])
    begin
      failures++;
      report_and_stop;
    end
  endtask
  initial
  begin
    void'($urandom(32'h64f6));
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1;
    chk(in_q | dac_q, 16'h0);
    chk({15'h0, sleep_n_o}, 16'h1);
    e = 16'h0;
    // word, byte and sync loads, awake then asleep
    for (k = 0; k < 6; k++)
    begin
      d = k ? $urandom : 16'hffff;
      old = dac_q;
      byte_mode <= k % 3 == 1;
      wr(`DDBL_ADDR_CTRL, {13'h0, k % 3 == 2, k % 3 == 1, k > 2});
      wr(`DDBL_ADDR_DATA, d);
      chk(in_q, e);
      e = exp_in(d);
      run(0);
      chk(in_q, e);
      chk(dac_q, k % 3 == 2 ? e : old);
      chk({15'h0, drive}, {15'h0, k < 3});
      run(1);
      chk(dac_q, e);
    end
    wr(`DDBL_ADDR_CTRL, 16'h0);
    rd(4'hf, s);
    chk(s, 16'h0);
    chk(in_q, e);
    run(2);
    chk(in_q | dac_q, 16'h0);
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
